// *** hw/ptbd_cfg.svh ***
// Register offsets, field positions and reset values of the texel decoder.
// Assumes byte addresses on an 8-bit AXI4-Lite address, one word per register.
`ifndef PTBD_CFG_SVH
`define PTBD_CFG_SVH

// =====================================================================
// Register offsets
`define PTBD_OFS_BLOCK_LO 8'h00
`define PTBD_OFS_BLOCK_HI 8'h04
`define PTBD_OFS_CTRL 8'h08
`define PTBD_OFS_TEXEL 8'h0C
`define PTBD_OFS_STATUS 8'h10

// =====================================================================
// Field positions
`define PTBD_OPAQUE_BIT 33
`define PTBD_FLIP_BIT 32
`define PTBD_CTRL_SRGB_BIT 8

// =====================================================================
// Reset values and constants
`define PTBD_RST_BLOCK 64'h0
`define PTBD_RST_SEL 4'h0
`define PTBD_RST_SRGB 1'b0
`define PTBD_ALPHA_FULL 8'hFF
`define PTBD_RESP_OKAY 2'h0
`define PTBD_RESP_SLVERR 2'h2

`endif

// *** hw/ptbd_decoder.sv ***
// Punch-through alpha texel block decoder with an AXI4-Lite register slave.
// Assumes one clock, a synchronous active-low reset and a single
// AXI4-Lite master that keeps at most one write and one read under way.
`include "ptbd_cfg.svh"

module ptbd_decoder
    import ptbd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] texel_rgba,
    output logic [1:0] texel_mode,
    output logic texel_srgb
);

    // =================================================================
    // Channel widening and arithmetic helpers
    function automatic logic [7:0] ext4(input logic [3:0] v);
        return {v, v};
    endfunction

    function automatic logic [7:0] ext5(input logic [4:0] v);
        return {v, v[4:2]};
    endfunction

    function automatic logic [7:0] ext6(input logic [5:0] v);
        return {v, v[5:4]};
    endfunction

    function automatic logic [7:0] ext7(input logic [6:0] v);
        return {v, v[6]};
    endfunction

    function automatic logic signed [13:0] wide8(input logic [7:0] v);
        return $signed({6'h00, v});
    endfunction

    function automatic logic [7:0] clamp8(input logic signed [13:0] v);
        if (v < 14'sh0000) begin
            return 8'h00;
        end else if (v > 14'sh00FF) begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction

    // Five-bit base plus signed three-bit delta leaves 0..31
    function automatic logic range_bad(input logic [4:0] v,
                                       input logic [2:0] d);
        logic [6:0] s;
        s = {2'h0, v} + {{4{d[2]}}, d};
        return s[6:5] != 2'h0;
    endfunction

    function automatic ptbd_mode_t sel_mode(input logic [63:0] b);
        if (range_bad(b[63:59], b[58:56])) begin
            return PTBD_T;
        end else if (range_bad(b[55:51], b[50:48])) begin
            return PTBD_H;
        end else if (range_bad(b[47:43], b[42:40])) begin
            return PTBD_PLANAR;
        end
        return PTBD_DIFF;
    endfunction

    // =================================================================
    // Lookup tables
    function automatic logic [7:0] mod_large(input logic [2:0] cw);
        unique case (cw)
            3'h0: return 8'h08;
            3'h1: return 8'h11;
            3'h2: return 8'h1D;
            3'h3: return 8'h2A;
            3'h4: return 8'h3C;
            3'h5: return 8'h50;
            3'h6: return 8'h6A;
            3'h7: return 8'hB7;
        endcase
    endfunction

    function automatic logic [7:0] mod_small(input logic [2:0] cw);
        unique case (cw)
            3'h0: return 8'h02;
            3'h1: return 8'h05;
            3'h2: return 8'h09;
            3'h3: return 8'h0D;
            3'h4: return 8'h12;
            3'h5: return 8'h18;
            3'h6: return 8'h21;
            3'h7: return 8'h2F;
        endcase
    endfunction

    function automatic logic [7:0] dist_lut(input logic [2:0] di);
        unique case (di)
            3'h0: return 8'h03;
            3'h1: return 8'h06;
            3'h2: return 8'h0B;
            3'h3: return 8'h10;
            3'h4: return 8'h17;
            3'h5: return 8'h20;
            3'h6: return 8'h29;
            3'h7: return 8'h40;
        endcase
    endfunction

    // Plane evaluation of one channel at texel (x, y)
    function automatic logic [7:0] planar_ch(input logic [7:0] o,
                                             input logic [7:0] h,
                                             input logic [7:0] v,
                                             input logic [1:0] x,
                                             input logic [1:0] y);
        logic signed [13:0] s;
        s = $signed({12'h000, x}) * (wide8(h) - wide8(o))
            + $signed({12'h000, y}) * (wide8(v) - wide8(o))
            + (wide8(o) <<< 2) + 14'sh0002;
        return clamp8(s >>> 2);
    endfunction

    // =================================================================
    // Texel decoder: returns {mode, alpha, blue, green, red}
    function automatic logic [33:0] decode_texel(input logic [63:0] b,
                                                 input logic [3:0] k);
        logic [1:0] ix;
        logic op;
        logic sub2;
        ptbd_mode_t md;
        logic [1:0] x;
        logic [1:0] y;
        logic [4:0] r5;
        logic [4:0] g5;
        logic [4:0] b5;
        logic [7:0] c1r;
        logic [7:0] c1g;
        logic [7:0] c1b;
        logic [7:0] c2r;
        logic [7:0] c2g;
        logic [7:0] c2b;
        logic [7:0] br;
        logic [7:0] bg;
        logic [7:0] bb;
        logic [2:0] cw;
        logic [7:0] lg;
        logic [7:0] sm;
        logic [2:0] di;
        logic signed [13:0] d;
        logic signed [13:0] off;
        logic [3:0] t_first_red_upper;
        logic [3:0] t_first_red_lower;
        logic [7:0] origin_red;
        logic [7:0] origin_blue;
        logic [7:0] horiz_red;
        logic [7:0] vert_red;
        logic [7:0] o_r;
        logic [7:0] o_g;
        logic [7:0] o_b;
        logic [7:0] o_a;
        ix = {b[{1'b1, k}], b[{1'b0, k}]};
        op = b[`PTBD_OPAQUE_BIT];
        md = sel_mode(b);
        x = k[3:2];
        y = k[1:0];
        r5 = b[63:59] + {{2{b[58]}}, b[58:56]};
        g5 = b[55:51] + {{2{b[50]}}, b[50:48]};
        b5 = b[47:43] + {{2{b[42]}}, b[42:40]};
        sub2 = b[`PTBD_FLIP_BIT] ? y[1] : x[1];
        cw = sub2 ? b[36:34] : b[39:37];
        lg = mod_large(cw);
        sm = op ? mod_small(cw) : 8'h00;
        t_first_red_upper = {2'h0, b[60:59]};
        t_first_red_lower = {2'h0, b[57:56]};
        c1r = 8'h00;
        c1g = 8'h00;
        c1b = 8'h00;
        c2r = ext4(b[47:44]);
        c2g = ext4(b[43:40]);
        c2b = ext4(b[39:36]);
        di = 3'h0;
        d = 14'sh0000;
        off = 14'sh0000;
        br = 8'h00;
        bg = 8'h00;
        bb = 8'h00;
        unique case (md)
            PTBD_DIFF: begin
                br = sub2 ? ext5(r5) : ext5(b[63:59]);
                bg = sub2 ? ext5(g5) : ext5(b[55:51]);
                bb = sub2 ? ext5(b5) : ext5(b[47:43]);
                unique case (ix)
                    2'h3: off = -wide8(lg);
                    2'h2: off = -wide8(sm);
                    2'h0: off = wide8(sm);
                    2'h1: off = wide8(lg);
                endcase
            end
            PTBD_T: begin
                c1r = ext4((t_first_red_upper << 2) | t_first_red_lower);
                c1g = ext4(b[55:52]);
                c1b = ext4(b[51:48]);
                di = {b[35:34], 1'b0} | {2'h0, b[32]};
                d = wide8(dist_lut(di));
                br = (ix == 2'h0) ? c1r : c2r;
                bg = (ix == 2'h0) ? c1g : c2g;
                bb = (ix == 2'h0) ? c1b : c2b;
                if (ix == 2'h1) begin
                    off = d;
                end else if (ix == 2'h3) begin
                    off = -d;
                end
            end
            PTBD_H: begin
                c1r = ext4(b[62:59]);
                c1g = ext4({b[58:56], 1'b0} | {3'h0, b[52]});
                c1b = ext4({b[51], 3'h0} | {1'b0, b[49:47]});
                c2r = ext4(b[46:43]);
                c2g = ext4(b[42:39]);
                c2b = ext4(b[38:35]);
                di = {b[34], b[32],
                      {c1r, c1g, c1b} >= {c2r, c2g, c2b}};
                d = wide8(dist_lut(di));
                br = ix[1] ? c2r : c1r;
                bg = ix[1] ? c2g : c1g;
                bb = ix[1] ? c2b : c1b;
                off = ix[0] ? -d : d;
            end
            PTBD_PLANAR: begin
                off = 14'sh0000;
            end
        endcase
        o_r = clamp8(wide8(br) + off);
        o_g = clamp8(wide8(bg) + off);
        o_b = clamp8(wide8(bb) + off);
        o_a = `PTBD_ALPHA_FULL;
        if (md == PTBD_PLANAR) begin
            origin_red = ext6(b[62:57]);
            origin_blue = ext6({b[48], b[44:43], b[41:39]});
            horiz_red = ext6({b[38:34], b[32]});
            vert_red = ext6(b[18:13]);
            o_r = planar_ch(origin_red, horiz_red, vert_red, x, y);
            o_g = planar_ch(ext7({b[56], b[54:49]}), ext7(b[31:25]),
                            ext7(b[12:6]), x, y);
            o_b = planar_ch(origin_blue, ext6(b[24:19]), ext6(b[5:0]),
                            x, y);
            o_a = `PTBD_ALPHA_FULL;
        end else if (!op && ix == 2'h2) begin
            o_r = 8'h00;
            o_g = 8'h00;
            o_b = 8'h00;
            o_a = 8'h00;
        end
        return {md, o_a, o_b, o_g, o_r};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i * 8 +: 8] = nw[i * 8 +: 8];
            end
        end
        return m;
    endfunction

    // =================================================================
    // State update
    ptbd_state_t s_reg;
    ptbd_state_t s_next;
    logic [33:0] dec;
    logic [31:0] wmerged;

    assign s_axi_awready = aresetn && !s_reg.aw_hold && !s_reg.bvalid;
    assign s_axi_wready = aresetn && !s_reg.w_hold && !s_reg.bvalid;
    assign s_axi_arready = aresetn && !s_reg.rvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign texel_rgba = s_reg.rgba;
    assign texel_mode = s_reg.mode;
    assign texel_srgb = s_reg.srgb;

    always_comb begin
        s_next = s_reg;
        dec = decode_texel(s_reg.blk, s_reg.sel);
        // sRGB flag never enters the decode path
        s_next.mode = ptbd_mode_t'(dec[33:32]);
        s_next.rgba = dec[31:0];
        s_next.idx = {s_reg.blk[{1'b1, s_reg.sel}],
                      s_reg.blk[{1'b0, s_reg.sel}]};
        s_next.opaque = s_reg.blk[`PTBD_OPAQUE_BIT];
        wmerged = 32'h0;
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_hold = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid) begin
            s_next.aw_hold = 1'b0;
            s_next.w_hold = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `PTBD_RESP_OKAY;
            unique case (s_reg.aw_addr)
                `PTBD_OFS_BLOCK_LO: begin
                    s_next.blk[31:0] = merge(s_reg.blk[31:0],
                                             s_reg.w_data, s_reg.w_strb);
                end
                `PTBD_OFS_BLOCK_HI: begin
                    s_next.blk[63:32] = merge(s_reg.blk[63:32],
                                              s_reg.w_data, s_reg.w_strb);
                end
                `PTBD_OFS_CTRL: begin
                    wmerged = merge({23'h0, s_reg.srgb, 4'h0, s_reg.sel},
                                    s_reg.w_data, s_reg.w_strb);
                    s_next.sel = wmerged[3:0];
                    s_next.srgb = wmerged[`PTBD_CTRL_SRGB_BIT];
                end
                `PTBD_OFS_TEXEL, `PTBD_OFS_STATUS: begin
                    s_next.bresp = `PTBD_RESP_OKAY;
                end
                default: begin
                    s_next.bresp = `PTBD_RESP_SLVERR;
                end
            endcase
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = `PTBD_RESP_OKAY;
            unique case (s_axi_araddr)
                `PTBD_OFS_BLOCK_LO: s_next.rdata = s_reg.blk[31:0];
                `PTBD_OFS_BLOCK_HI: s_next.rdata = s_reg.blk[63:32];
                `PTBD_OFS_CTRL: begin
                    s_next.rdata = {23'h0, s_reg.srgb, 4'h0, s_reg.sel};
                end
                `PTBD_OFS_TEXEL: s_next.rdata = s_reg.rgba;
                `PTBD_OFS_STATUS: begin
                    s_next.rdata = {23'h0, s_reg.srgb, 5'h0,
                                    s_reg.opaque ||
                                    (s_reg.mode == PTBD_PLANAR),
                                    s_reg.mode};
                end
                default: begin
                    s_next.rdata = 32'h0;
                    s_next.rresp = `PTBD_RESP_SLVERR;
                end
            endcase
        end
        if (!aresetn) begin
            s_next = '0;
            s_next.blk = `PTBD_RST_BLOCK;
            s_next.sel = `PTBD_RST_SEL;
            s_next.srgb = `PTBD_RST_SRGB;
            s_next.rgba = {`PTBD_ALPHA_FULL, 24'h0};
        end
    end

    always_ff @(posedge aclk) begin
        s_reg <= s_next;
    end

    // =================================================================
    // Checks
    planar_alpha_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.mode == PTBD_PLANAR |-> s_reg.rgba[31:24] == 8'hFF)
        else $error("planar texel alpha not full");

    punch_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.mode != PTBD_PLANAR && !s_reg.opaque && s_reg.idx == 2'h2
        |-> s_reg.rgba == 32'h0)
        else $error("punch-through texel not zero");

    opaque_alpha_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.opaque |-> s_reg.rgba[31:24] == 8'hFF)
        else $error("opaque block gave transparent texel");

    alpha_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.rgba[31:24] != 8'hFF |-> s_reg.rgba == 32'h0)
        else $error("transparent texel keeps colour");

    planar_opaque_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.mode == PTBD_PLANAR && !s_reg.opaque && s_reg.idx == 2'h2
        |-> s_reg.rgba[31:24] == 8'hFF)
        else $error("planar block used opaque bit");

    mode_t_a: assert property (@(posedge aclk) disable iff (!aresetn)
        range_bad(s_reg.blk[63:59], s_reg.blk[58:56])
        |=> s_reg.mode == PTBD_T)
        else $error("red overflow did not select T mode");

    mode_h_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !range_bad(s_reg.blk[63:59], s_reg.blk[58:56]) &&
        range_bad(s_reg.blk[55:51], s_reg.blk[50:48])
        |=> s_reg.mode == PTBD_H)
        else $error("green overflow did not select H mode");

    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.bvalid && !s_axi_bready |=> s_reg.bvalid && $stable(s_reg.bresp))
        else $error("write response dropped early");

    rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.rvalid && !s_axi_rready |=> s_reg.rvalid && $stable(s_reg.rdata))
        else $error("read data dropped early");

    write_lo_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid &&
        s_reg.aw_addr == 8'h00 && s_reg.w_strb == 4'hF
        |=> s_reg.blk[31:0] == $past(s_reg.w_data) ##1
            s_reg.rgba == $past(dec[31:0]))
        else $error("block word write not taken");

endmodule // ptbd_decoder

// *** hw/ptbd_pkg.sv ***
// Types shared by the punch-through texel block decoder.
// Assumes the offsets and field positions come from ptbd_cfg.svh.
package ptbd_pkg;

    // =================================================================
    // Block coding modes
    typedef enum logic [1:0] {
        PTBD_DIFF,
        PTBD_T,
        PTBD_H,
        PTBD_PLANAR
    } ptbd_mode_t;

    // =================================================================
    // Whole state of the decoder
    typedef struct packed {
        logic [63:0] blk;
        logic [3:0] sel;
        logic srgb;
        logic [31:0] rgba;
        ptbd_mode_t mode;
        logic [1:0] idx;
        logic opaque;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ptbd_state_t;

endpackage

// *** tb/ptbd_host.sv ***
// Sampler-side bus master model: AXI4-Lite register reads and writes.
// Assumes tb_top provides error_cnt and end_of_test.
module ptbd_host (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic hang();
        tb_top.error_cnt++;
        tb_top.end_of_test();
    endtask
    // One write (w high) or one read, each channel held until taken
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
            if (s_axi_rready && s_axi_rvalid) begin
                r = s_axi_rresp;
                q = s_axi_rdata;
                s_axi_rready <= 1'b0;
            end
            if (++n > 50) hang();
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready ||
            s_axi_arvalid || s_axi_rready);
    endtask
endmodule // ptbd_host

// *** tb/tb_top.sv ***
// Self-checking bench for the texel block decoder, all modes.
// Assumes ptbd_host as register master and the design's cfg header.
`include "ptbd_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, texel_srgb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, texel_rgba, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, texel_mode, rs;
    int error_cnt = 0;
    int tests_run = 0;
    // Block hi, block lo, 12-bit control, expected texel
    localparam logic [107:0] tab [24] = '{
        108'hE020184200000001000FF353EFF, 108'hE020184200010001000FF0004CA,
        108'hE020184200010000000FF0F18DE, 108'hE020184200000000000FF212AF0,
        108'hE02018400001000000000000000, 108'hE020184000000000000FF1821E7,
        108'hE020185E00000100008FFCFD8FF, 108'hE020185F00000100008FF353EFF,
        108'hFB00888B00000000000FF0000FF, 108'hFB00888B00000001000FFA8A8A8,
        108'hFB00888B00010000000FF888888, 108'hFB00888B00010001000FF686868,
        108'hFB0088890001000000000000000, 108'h00FB000200000000000FFF41706,
        108'h00FB000200000001000FFE80B00, 108'h00FB000200010000000FF060606,
        108'h00FB000200010001000FF000000, 108'h00FB00000001000000000000000,
        108'h0000FB0000010000000FF790000, 108'h0000FB0000010000001FF5B0008,
        108'h0000FB0000000000004FF5B0000, 108'h0000FB0000000000005FF3D0000,
        108'h0000FB000000000000FFF000000, 108'h0000FB0000000000105FF3D0000
    };
    ptbd_decoder dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
        .s_axi_wstrb(4'hF));
    ptbd_host host (.*);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) error_cnt++;
        if (g !== e) $display("[ERR] %s expected %h seen %h", s, e, g);
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic dec(input int i, input logic [1:0] m);
        host.xfer(1'b1, `PTBD_OFS_BLOCK_LO, tab[i][75:44], rv, rs);
        host.xfer(1'b1, `PTBD_OFS_BLOCK_HI, tab[i][107:76], rv, rs);
        host.xfer(1'b1, `PTBD_OFS_CTRL, {20'h0, tab[i][43:32]}, rv, rs);
        host.xfer(1'b0, `PTBD_OFS_TEXEL, 32'h0, rv, rs);
        chk("texel", tab[i][31:0], rv);
        chk("texel port", tab[i][31:0], texel_rgba);
        chk("mode", {30'h0, m}, {30'h0, texel_mode});
        chk("srgb", {31'h0, tab[i][40]}, {31'h0, texel_srgb});
    endtask
    task automatic t_regs();
        host.xfer(1'b0, `PTBD_OFS_TEXEL, 32'h0, rv, rs);
        chk("reset texel", 32'hFF000000, rv);
        host.xfer(1'b0, `PTBD_OFS_STATUS, 32'h0, rv, rs);
        chk("reset status", 32'h0, rv);
        host.xfer(1'b0, 8'h20, 32'h0, rv, rs);
        chk("unmapped rresp", {30'h0, `PTBD_RESP_SLVERR}, {30'h0, rs});
        host.xfer(1'b1, 8'h20, 32'h0, rv, rs);
        chk("unmapped bresp", {30'h0, `PTBD_RESP_SLVERR}, {30'h0, rs});
        host.xfer(1'b1, `PTBD_OFS_TEXEL, 32'h0, rv, rs);
        chk("read-only bresp", {30'h0, `PTBD_RESP_OKAY}, {30'h0, rs});
    endtask
    task automatic t_diff();
        for (int i = 0; i < 8; i++) dec(i, 2'h0);
    endtask
    task automatic t_tmode();
        for (int i = 8; i < 13; i++) dec(i, 2'h1);
    endtask
    task automatic t_hmode();
        for (int i = 13; i < 18; i++) dec(i, 2'h2);
    endtask
    task automatic t_planar();
        for (int i = 18; i < 24; i++) dec(i, 2'h3);
        host.xfer(1'b0, `PTBD_OFS_STATUS, 32'h0, rv, rs);
        chk("planar status", 32'h00000107, rv);
    endtask
    initial begin
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_diff();
        t_tmode();
        t_hmode();
        t_planar();
        end_of_test();
    end
endmodule // tb_top
